// >>> design/hvc_pkg.sv
package hvc_pkg;

  // Register offsets on the plain register port (byte addresses).
  localparam logic [3:0] ADDR_CFG    = 4'h0;
  localparam logic [3:0] ADDR_THR    = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // Field positions in the configuration register.
  localparam int CFG_HYST_BIT    = 0;
  localparam int CFG_FS_EN_BIT   = 1;
  localparam int CFG_CHM_EN_BIT  = 2;
  localparam int CFG_PWM_EN_BIT  = 3;
  localparam int CFG_CHM_BIT     = 4;
  localparam int CFG_FD_BIT      = 5;
  localparam int CFG_TOFF_LSB    = 8;
  localparam int CFG_TOFF_W      = 4;

  // Field positions in the status register.
  localparam int STS_HIGH_BIT    = 0;
  localparam int STS_FS_BIT      = 1;
  localparam int STS_PWM_BIT     = 2;
  localparam int STS_ARMED_BIT   = 3;

  // Reset values.
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] THR_RESET = 32'h0000_0000;

  // Hysteresis shifts: 1/16 when the bit is clear, 1/32 when set.
  localparam int HYST_SHIFT_WIDE   = 4;
  localparam int HYST_SHIFT_NARROW = 5;

  // A 45 degree point is where the low bits of the position equal this.
  localparam logic [7:0] POS_45_LOW = 8'h80;

endpackage

// >>> design/hvc_speed_cmp.sv
`timescale 1ns/1ps
// Velocity comparator with hysteresis against the upper speed threshold.
module hvc_speed_cmp #(
  parameter int TPW = 20
) (
  input  wire logic           clk_sys,
  input  wire logic           rst,
  input  wire logic [TPW-1:0] measured_step_period,
  input  wire logic [TPW-1:0] upper_speed_threshold,
  input  wire logic           hyst_narrow,
  output logic                high_vel_r
);

  initial
  begin
    if (TPW < 8 || TPW > 32)
      $error("hvc_speed_cmp: TPW out of range");
  end

  // Period scaled by 15/16 or 31/32, minus one, saturating at zero.
  function automatic logic [TPW-1:0] scale_period(
    input logic [TPW-1:0] p,
    input logic           narrow
  );
    logic [TPW-1:0] part;
    part = narrow ? (p >> hvc_pkg::HYST_SHIFT_NARROW)
                  : (p >> hvc_pkg::HYST_SHIFT_WIDE);
    if (p - part == '0)
      scale_period = '0;
    else
      scale_period = p - part - TPW'(1);
  endfunction

  logic [TPW-1:0] scaled_period;
  logic           enter_high;
  logic           stay_high;
  logic           high_vel_nxt;

  // Entering uses the raw period, staying uses the scaled one, so a
  // period hovering at the threshold does not make the mode chatter.
  assign scaled_period = scale_period(measured_step_period, hyst_narrow);
  assign enter_high    = measured_step_period <= upper_speed_threshold;
  assign stay_high     = scaled_period <= upper_speed_threshold;
  assign high_vel_nxt  = high_vel_r ? stay_high : enter_high;

  // Velocity state register.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      high_vel_r <= 1'b0;
    else
      high_vel_r <= high_vel_nxt;
  end

  chk_enter_raw_period: assert property (@(posedge clk_sys) disable iff (rst)
    (!high_vel_r && measured_step_period <= upper_speed_threshold) |=> high_vel_r)
    else $error("Velocity state missed entering high velocity.");

  chk_leave_scaled: assert property (@(posedge clk_sys) disable iff (rst)
    (high_vel_r && !hyst_narrow &&
     measured_step_period - (measured_step_period >> 4) - TPW'(1)
       > upper_speed_threshold && measured_step_period > 16)
    |=> !high_vel_r)
    else $error("Velocity state did not leave high velocity.");

endmodule

// >>> design/hvc_fs_gate.sv
`timescale 1ns/1ps
// Fullstep switch that changes state only at a 45 degree position.
module hvc_fs_gate #(
  parameter int MW = 10,
  parameter int CW = 9
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          fs_request,
  input  wire logic [MW-1:0] ustep_position,
  input  wire logic [CW-1:0] table_cur_a,
  input  wire logic [CW-1:0] table_cur_b,
  output logic               fullstep_r,
  output logic [CW-1:0]      fs_cur_a_r,
  output logic [CW-1:0]      fs_cur_b_r
);

  initial
  begin
    if (MW < 8)
      $error("hvc_fs_gate: MW must be at least 8");
  end

  logic at_45;

  // A 45 degree point sits in the middle of every quarter wave.
  assign at_45 = ustep_position[7:0] == hvc_pkg::POS_45_LOW;

  // Mode changes both ways only at 45 degrees to keep the current steady.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      fullstep_r <= 1'b0;
    else if (at_45)
      fullstep_r <= fs_request;
  end

  // The table entry at 45 degrees is kept as the fullstep target current.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fs_cur_a_r <= '0;
      fs_cur_b_r <= '0;
    end
    else if (at_45)
    begin
      fs_cur_a_r <= table_cur_a;
      fs_cur_b_r <= table_cur_b;
    end
  end

  chk_fs_only_45: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(fullstep_r) |-> $past(ustep_position[7:0]) == hvc_pkg::POS_45_LOW)
    else $error("Fullstep entered away from 45 degrees.");

endmodule

// >>> design/hvc_chopper_switch.sv
`timescale 1ns/1ps
module hvc_chopper_switch #(
  parameter int TPW = 20,
  parameter int MW  = 10,
  parameter int CW  = 9
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata_r,
  input  wire logic [TPW-1:0] measured_step_period,
  input  wire logic          standstill,
  input  wire logic [MW-1:0] ustep_position,
  input  wire logic [CW-1:0] table_cur_a,
  input  wire logic [CW-1:0] table_cur_b,
  output logic [CW-1:0]      coil_cur_a_r,
  output logic [CW-1:0]      coil_cur_b_r,
  output logic               fullstep_r,
  output logic               chm_r,
  output logic               fast_decay_select_r,
  output logic [4:0]         toff_r,
  output logic               pwm_active_r,
  output logic               high_vel_r
);

  initial
  begin
    // The threshold read-back pads with zeros, so a full word is refused.
    if (TPW < 8 || TPW > 31 || CW < 1 || MW < 8)
      $error("hvc_chopper_switch: unsupported width");
  end

  // Software-written configuration and threshold.
  logic [31:0]    cfg_r;
  logic [TPW-1:0] thr_r;
  logic           pwm_armed_r;
  logic           pwm_armed_nxt;

  // Results from the leaf blocks.
  logic           high_vel_w;
  logic           fs_state_w;
  logic [CW-1:0]  fs_cur_a_w;
  logic [CW-1:0]  fs_cur_b_w;

  // Decoded configuration bits.
  logic           hyst_narrow;
  logic           fs_en;
  logic           chm_en;
  logic           pwm_en;
  logic           chm_base;
  logic           fd_base;
  logic [3:0]     toff_base;

  assign hyst_narrow = cfg_r[hvc_pkg::CFG_HYST_BIT];
  assign fs_en       = cfg_r[hvc_pkg::CFG_FS_EN_BIT];
  assign chm_en      = cfg_r[hvc_pkg::CFG_CHM_EN_BIT];
  assign pwm_en      = cfg_r[hvc_pkg::CFG_PWM_EN_BIT];
  assign chm_base    = cfg_r[hvc_pkg::CFG_CHM_BIT];
  assign fd_base     = cfg_r[hvc_pkg::CFG_FD_BIT];
  assign toff_base   = cfg_r[hvc_pkg::CFG_TOFF_LSB +: hvc_pkg::CFG_TOFF_W];

  // Register port decode.
  logic wr_cfg;
  logic wr_thr;
  logic rd_cfg;
  logic rd_thr;
  logic rd_sts;

  assign wr_cfg = reg_wr && reg_addr == hvc_pkg::ADDR_CFG;
  assign wr_thr = reg_wr && reg_addr == hvc_pkg::ADDR_THR;
  assign rd_cfg = reg_rd && reg_addr == hvc_pkg::ADDR_CFG;
  assign rd_thr = reg_rd && reg_addr == hvc_pkg::ADDR_THR;
  assign rd_sts = reg_rd && reg_addr == hvc_pkg::ADDR_STATUS;

  // Configuration and threshold registers.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cfg_r <= hvc_pkg::CFG_RESET;
      thr_r <= hvc_pkg::THR_RESET[TPW-1:0];
    end
    else
    begin
      if (wr_cfg)
        cfg_r <= reg_wdata;
      if (wr_thr)
        thr_r <= reg_wdata[TPW-1:0];
    end
  end

  // Status word and read mux; unmapped addresses read as zero.
  logic [31:0] status_w;
  logic [31:0] rdata_nxt;

  assign status_w  = {28'h0, pwm_armed_r, pwm_active_r, fullstep_r,
                      high_vel_r};
  assign rdata_nxt = rd_cfg ? cfg_r
                   : rd_thr ? {{(32-TPW){1'b0}}, thr_r}
                   : rd_sts ? status_w
                   : 32'h0000_0000;

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata_r <= 32'h0000_0000;
    else
      reg_rdata_r <= rdata_nxt;
  end

  // Velocity comparison against the upper speed threshold.
  hvc_speed_cmp #(
    .TPW (TPW)
  ) u_cmp (
    .clk_sys               (clk_sys),
    .rst                   (rst),
    .measured_step_period  (measured_step_period),
    .upper_speed_threshold (thr_r),
    .hyst_narrow           (hyst_narrow),
    .high_vel_r            (high_vel_w)
  );

  // Fullstep is only requested when its enable is set.
  logic fs_request;

  assign fs_request = fs_en && high_vel_w;

  hvc_fs_gate #(
    .MW (MW),
    .CW (CW)
  ) u_fs (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .fs_request     (fs_request),
    .ustep_position (ustep_position),
    .table_cur_a    (table_cur_a),
    .table_cur_b    (table_cur_b),
    .fullstep_r     (fs_state_w),
    .fs_cur_a_r     (fs_cur_a_w),
    .fs_cur_b_r     (fs_cur_b_w)
  );

  // Chopper override; independent of the fullstep path so both can act.
  logic       chm_force;
  logic       chm_nxt;
  logic       fd_nxt;
  logic [4:0] toff_nxt;

  assign chm_force = chm_en && high_vel_w;
  assign chm_nxt   = chm_force ? 1'b1 : chm_base;
  assign fd_nxt    = chm_force ? 1'b0 : fd_base;
  // Doubling keeps the chopper frequency from doubling while chm_force holds.
  assign toff_nxt  = chm_force ? {toff_base, 1'b0}
                               : {1'b0, toff_base};

  // A rising enable is held back until standstill; a falling one acts now.
  assign pwm_armed_nxt = !pwm_en ? 1'b0
                       : (pwm_armed_r || standstill);

  // Coil current: fullstep uses the held 45 degree entry.
  logic [CW-1:0] cur_a_nxt;
  logic [CW-1:0] cur_b_nxt;

  assign cur_a_nxt = fs_state_w ? fs_cur_a_w : table_cur_a;
  assign cur_b_nxt = fs_state_w ? fs_cur_b_w : table_cur_b;

  // Output registers; every output comes straight from a flip-flop.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      chm_r               <= 1'b0;
      fast_decay_select_r <= 1'b0;
      toff_r              <= 5'h00;
      pwm_armed_r         <= 1'b0;
      pwm_active_r        <= 1'b0;
      fullstep_r          <= 1'b0;
      high_vel_r          <= 1'b0;
      coil_cur_a_r        <= '0;
      coil_cur_b_r        <= '0;
    end
    else
    begin
      chm_r               <= chm_nxt;
      fast_decay_select_r <= fd_nxt;
      toff_r              <= toff_nxt;
      pwm_armed_r         <= pwm_armed_nxt;
      pwm_active_r        <= pwm_armed_nxt && !high_vel_w;
      fullstep_r          <= fs_state_w;
      high_vel_r          <= high_vel_w;
      coil_cur_a_r        <= cur_a_nxt;
      coil_cur_b_r        <= cur_b_nxt;
    end
  end

  // Checks next to the logic they guard.
  chk_chm_forced_high: assert property (@(posedge clk_sys) disable iff (rst)
    (chm_en && high_vel_w) |=> (chm_r && !fast_decay_select_r))
    else $error("Chopper mode not forced at high velocity.");

  chk_toff_doubled: assert property (@(posedge clk_sys) disable iff (rst)
    (chm_en && high_vel_w) |=> toff_r == {$past(toff_base), 1'b0})
    else $error("Off time not doubled at high velocity.");

  chk_chm_unchanged: assert property (@(posedge clk_sys) disable iff (rst)
    !chm_en |=> (chm_r == $past(chm_base) &&
                 fast_decay_select_r == $past(fd_base) &&
                 toff_r == {1'b0, $past(toff_base)}))
    else $error("Chopper mode changed while override disabled.");

  chk_no_fs_disabled: assert property (@(posedge clk_sys) disable iff (rst)
    (!fs_en && !fs_state_w) |=> !fs_state_w)
    else $error("Fullstep entered with enable clear.");

  chk_fs_current: assert property (@(posedge clk_sys) disable iff (rst)
    fs_state_w |=> (coil_cur_a_r == $past(fs_cur_a_w) &&
                   coil_cur_b_r == $past(fs_cur_b_w)))
    else $error("Fullstep current is not the held 45 degree entry.");

  chk_pwm_standstill: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(pwm_armed_r) |-> $past(standstill))
    else $error("Quiet PWM armed while moving.");

  chk_pwm_off_fast: assert property (@(posedge clk_sys) disable iff (rst)
    !pwm_en |=> (!pwm_armed_r && !pwm_active_r))
    else $error("Quiet PWM stayed on after disable.");

  chk_both_modes: assert property (@(posedge clk_sys) disable iff (rst)
    (fs_state_w && chm_en && high_vel_w) |=> (fullstep_r && chm_r))
    else $error("Fullstep and chopper change did not coexist.");

  // Quiet PWM is never active while the velocity is above the threshold.
  chk_pwm_not_high: assert property (@(posedge clk_sys) disable iff (rst)
    high_vel_w |=> !pwm_active_r)
    else $error("Quiet PWM active at high velocity.");

  // A forced mode must fall back to the base bits once velocity drops.
  chk_chm_release: assert property (@(posedge clk_sys) disable iff (rst)
    !high_vel_w |=> (chm_r == $past(chm_base) &&
                     fast_decay_select_r == $past(fd_base)))
    else $error("Chopper mode stayed forced below the threshold.");

  // Read data must not linger past the single cycle after a strobe.
  chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> reg_rdata_r == 32'h0000_0000)
    else $error("Read data present without a read strobe.");

  // The exported velocity flag follows the internal one by one cycle.
  chk_hv_follow: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> high_vel_r == $past(high_vel_w))
    else $error("Velocity flag output does not follow its state.");

endmodule

// >>> test/hvc_testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata_r;
  logic [19:0] per_in = 20'hfffff;
  logic        ss = 1'b0;
  logic [9:0]  pos = 10'h005;
  logic [8:0]  tab_a = 9'h0;
  logic [8:0]  tab_b = 9'h0;
  logic [8:0]  cur_a;
  logic [8:0]  cur_b;
  logic [4:0]  toff_o;
  logic        fs_o;
  logic        chm_o;
  logic        fd_o;
  logic        pwm_o;
  logic        hv_o;
  logic        smp = 1'b0;
  logic        rd_was = 1'b0;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [31:0] cfg = 32'h0;
  logic [31:0] thr = 32'h0;
  logic        hv_m = 1'b0;
  logic        fs_m = 1'b0;
  logic        armed = 1'b0;
  logic [8:0]  cap_a = 9'h0;
  logic [8:0]  cap_b = 9'h0;
  logic [31:0] rd_q[$];
  logic [27:0] ob_q[$];
  logic [19:0] pv[9] = '{20'd2000, 20'd1001, 20'd1000, 20'd1033, 20'd1034,
                         20'd1067, 20'd1068, 20'd1001, 20'd2000};
  wire  [27:0] obs = {cur_a, cur_b, toff_o, fd_o, chm_o, pwm_o, fs_o, hv_o};

  always #5 clk_sys = ~clk_sys;

  hvc_chopper_switch #(.TPW(20), .MW(10), .CW(9)) hvc_chopper_switch_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .measured_step_period(per_in),
    .standstill(ss), .ustep_position(pos), .table_cur_a(tab_a),
    .table_cur_b(tab_b), .coil_cur_a_r(cur_a), .coil_cur_b_r(cur_b),
    .fullstep_r(fs_o), .chm_r(chm_o), .fast_decay_select_r(fd_o),
    .toff_r(toff_o), .pwm_active_r(pwm_o), .high_vel_r(hv_o));

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // The watcher compares at the falling edge, when registered outputs settle.
  always @(negedge clk_sys)
  begin
    if (rd_was)
      cmp("reg_rdata_r", rd_q.pop_front(), reg_rdata_r);
    if (smp)
      cmp("outputs", {4'h0, ob_q.pop_front()}, {4'h0, obs});
  end

  // Read data belong to the cycle after the strobe; a hang ends the run.
  always @(posedge clk_sys)
  begin
    rd_was <= reg_rd;
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      wrap_up();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  // Entry needs period at or below the threshold, exit the scaled period.
  function automatic logic hv_next(input logic [19:0] p);
    logic [19:0] d;
    d = p - (p >> (cfg[0] ? 5 : 4)) - 20'h1;
    return hv_m ? !(d > thr[19:0]) : (p <= thr[19:0]);
  endfunction

  function automatic logic [27:0] exp_out();
    logic sw;
    sw = cfg[2] & hv_m;
    return {fs_m ? cap_a : tab_a, fs_m ? cap_b : tab_b,
            sw ? {cfg[11:8], 1'b0} : {1'b0, cfg[11:8]},
            sw ? 1'b0 : cfg[5], sw | cfg[4], armed & ~hv_m, fs_m, hv_m};
  endfunction

  task automatic look();
    ob_q.push_back(exp_out());
    @(posedge clk_sys);
    smp <= 1'b1;
    @(posedge clk_sys);
    smp <= 1'b0;
    rd(hvc_pkg::ADDR_STATUS, {28'h0, armed, armed & ~hv_m, fs_m, hv_m});
  endtask

  // Fullstep state and captured currents only move at a 45 degree point.
  task automatic step(input logic [19:0] p, input logic [9:0] q,
                      input logic s);
    logic [8:0] a;
    logic [8:0] b;
    a = 9'($urandom);
    b = 9'($urandom);
    @(posedge clk_sys);
    per_in <= p;
    pos <= q;
    ss <= s;
    tab_a <= a;
    tab_b <= b;
    hv_m = hv_next(p);
    if (q[7:0] == 8'h80)
    begin
      fs_m = cfg[1] & hv_m;
      cap_a = a;
      cap_b = b;
    end
    if (!cfg[3]) armed = 1'b0;
    else if (s) armed = 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic wcfg(input logic [31:0] d);
    cfg = d;
    wr(hvc_pkg::ADDR_CFG, d);
    if (!cfg[3]) armed = 1'b0;
    else if (ss) armed = 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask

  initial
  begin
    void'($urandom(32'h348ec0a1));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(hvc_pkg::ADDR_CFG, 32'h0);
    rd(hvc_pkg::ADDR_THR, 32'h0);
    rd(4'hc, 32'h0);
    wr(hvc_pkg::ADDR_STATUS, 32'hf);
    look();
    $display("Test registers done");
    thr = 32'd1000;
    wr(hvc_pkg::ADDR_THR, thr);
    rd(hvc_pkg::ADDR_THR, thr);
    for (int h = 0; h < 2; h++)
    begin
      wcfg(32'(h));
      foreach (pv[i])
      begin
        step(pv[i], 10'h005, 1'b0);
        look();
      end
    end
    repeat (16)
    begin
      step(20'd960 + 20'($urandom_range(0, 120)), 10'h005, 1'b0);
      look();
    end
    $display("Test thresholds done");
    for (int k = 0; k < 4; k++)
    begin
      wcfg(($urandom & 32'h0000_0f30) | (k[0] ? 32'h4 : 32'h0));
      rd(hvc_pkg::ADDR_CFG, cfg);
      step(20'd2000, 10'h005, 1'b0);
      look();
      step(20'd900, 10'h005, 1'b0);
      look();
      step(20'd2000, 10'h005, 1'b0);
      look();
    end
    $display("Test chopper change done");
    wcfg(32'h0000_0306);
    step(20'd2000, 10'h005, 1'b0);
    step(20'd900, 10'h005, 1'b0);
    look();
    step(20'd900, 10'h280, 1'b0);
    look();
    step(20'd900, 10'h013, 1'b0);
    look();
    step(20'd2000, 10'h013, 1'b0);
    look();
    step(20'd2000, 10'h080, 1'b0);
    look();
    wcfg(32'h0000_0304);
    step(20'd900, 10'h180, 1'b0);
    look();
    $display("Test fullstep done");
    step(20'd2000, 10'h005, 1'b0);
    wcfg(32'h0000_0008);
    look();
    step(20'd2000, 10'h005, 1'b1);
    look();
    step(20'd900, 10'h005, 1'b0);
    look();
    step(20'd2000, 10'h005, 1'b0);
    look();
    wcfg(32'h0);
    look();
    wcfg(32'h0000_0008);
    look();
    $display("Test quiet chopper done");
    repeat (4) @(posedge clk_sys);
    wrap_up();
  end
endmodule
